//--- shared/msrs_regs.svh
// offsets, codes, limits and timing counts of the query handler
`ifndef MSRS_REGS_SVH
`define MSRS_REGS_SVH

// ********************************************
// function and exception codes
// ********************************************
`define MSRS_FC_READ        8'h03
`define MSRS_FC_WRITE       8'h06
`define MSRS_EXC_FLAG       8'h80
`define MSRS_EXC_FUNC       8'h01
`define MSRS_EXC_ADDR       8'h02
`define MSRS_EXC_DATA       8'h03

// ********************************************
// register window
// ********************************************
`define MSRS_READ_LAST      16'h0011
`define MSRS_QTY_MIN        16'h0001
`define MSRS_QTY_MAX        16'h0012
`define MSRS_REG_COUNT      17'h00012
`define MSRS_WRITE_FIRST    16'h0005
`define MSRS_WRITE_LAST     16'h0011
`define MSRS_HOLD_WORDS     13
`define MSRS_HOLD_RESET     16'h0000
`define MSRS_OFF_UNITS      16'h000B
`define MSRS_OFF_HOLD_CLR   16'h000E
`define MSRS_WIRE_BASE_NUM  40001

// ********************************************
// sensor limits
// ********************************************
`define MSRS_TEMP_MAX_C     16'h01F4
`define MSRS_F_ZERO         16'h0140
`define MSRS_HUM_MAX        16'h0064
`define MSRS_FAN_MAX        3'h4

// ********************************************
// frame checking and timing
// ********************************************
`define MSRS_CRC_INIT       16'hFFFF
`define MSRS_CRC_POLY       16'hA001
`define MSRS_QUERY_BYTES    4'h8
`define MSRS_CLK_HZ         125000000
`define MSRS_BAUD           9600
`define MSRS_CHAR_BITS      11
`define MSRS_SILENCE_TENTHS 35
`define MSRS_SILENCE_CYCLES ((64'd`MSRS_SILENCE_TENTHS * 64'd`MSRS_CHAR_BITS * \
  64'd`MSRS_CLK_HZ + 64'd10 * 64'd`MSRS_BAUD - 64'd1) / (64'd10 * 64'd`MSRS_BAUD))
`define MSRS_LAT_STEP_MS    50
`define MSRS_LAT_STEP_CYCLES (64'd`MSRS_LAT_STEP_MS * 64'd`MSRS_CLK_HZ / 64'd1000)

`endif

//--- shared/msrs_pkg.sv
// types shared by the query handler and its bench
package msrs_pkg;

  typedef enum logic [1:0] {ST_LISTEN, ST_WAIT, ST_SEND} msrs_state_t;

  typedef enum logic [1:0] {REPLY_READ, REPLY_WRITE, REPLY_EXC} msrs_reply_t;

  // first six query bytes in wire order
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] offset;
    logic [15:0] word;
  } msrs_query_t;

  typedef struct packed {
    logic       di_shorted;
    logic [2:0] fan_pos;
    logic       hold_press;
  } msrs_sense_t;

  // option straps: high when the option is fitted
  typedef struct packed {
    logic di;
    logic rh;
    logic fan;
    logic hold;
  } msrs_fit_t;

endpackage

//--- hdl/msrs_slave.sv
// serial register-protocol query handler for the sensor unit
`timescale 1ns/10ps
`include "msrs_regs.svh"

module msrs_slave #(
  parameter int unsigned SILENCE_CYCLES  = 32'(`MSRS_SILENCE_CYCLES),
  parameter int unsigned LAT_STEP_CYCLES = 32'(`MSRS_LAT_STEP_CYCLES)
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_error,
  input  wire logic                  tx_ready,
  input  wire logic [7:0]            slave_address,
  input  wire logic [2:0]            latency_sel,
  input  wire msrs_pkg::msrs_sense_t sense,
  input  wire msrs_pkg::msrs_fit_t   fitted,
  input  wire logic [15:0]           temp_tenths_c,
  input  wire logic [15:0]           humidity_pct,
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  output logic                       line_drive
);
  import msrs_pkg::*;

  // ********************************************
  // helpers
  // ********************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MSRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // truncating divide: tenths not a multiple of five lose a fraction, never gain one
  function automatic logic [15:0] tenths_c_to_f(input logic [15:0] c);
    logic [31:0] t;
    t = (32'(c) * 32'h0000_0009) / 32'h0000_0005;
    return 16'(t) + `MSRS_F_ZERO;
  endfunction

  // ********************************************
  // pin synchronisers
  // ********************************************
  // config pins and option straps are slow levels from outside
  // rx and tx handshakes share this clock and need no synchroniser
  logic [19:0] sync1_q;
  logic [19:0] sync2_q;

  always_ff @(posedge clock) begin
    sync1_q <= {slave_address, latency_sel, sense, fitted};
    sync2_q <= sync1_q;
  end

  wire [7:0]        addr_s = sync2_q[19:12];
  wire [2:0]        lat_s  = sync2_q[11:9];
  wire msrs_sense_t sns_s  = sync2_q[8:4];
  wire msrs_fit_t   fit_s  = sync2_q[3:0];

  // ********************************************
  // state
  // ********************************************
  msrs_state_t  state_q;
  msrs_reply_t  kind_q;
  msrs_query_t  q_q;
  logic [3:0]   rx_cnt_q;
  logic         rx_bad_q;
  logic [15:0]  rx_crc_q;
  logic [31:0]  idle_q;
  logic [31:0]  wait_q;
  logic [5:0]   idx_q;
  logic [15:0]  tx_crc_q;
  logic [7:0]   exc_q;
  logic         tx_valid_q;
  logic [7:0]   tx_data_q;
  logic         drive_q;
  logic         hold_flag_q;
  logic [15:0]  hold_q [0:`MSRS_HOLD_WORDS-1];

  // ********************************************
  // query decode
  // ********************************************
  wire        is_read  = q_q.func == `MSRS_FC_READ;
  wire        is_write = q_q.func == `MSRS_FC_WRITE;
  wire [16:0] rd_end   = {1'b0, q_q.offset} + {1'b0, q_q.word};
  wire        rd_ok    = q_q.offset <= `MSRS_READ_LAST
                      && q_q.word >= `MSRS_QTY_MIN
                      && q_q.word <= `MSRS_QTY_MAX
                      && rd_end <= `MSRS_REG_COUNT;
  wire        wr_ok    = q_q.offset >= `MSRS_WRITE_FIRST
                      && q_q.offset <= `MSRS_WRITE_LAST;
  wire        addr_hit = q_q.addr == addr_s && addr_s != 8'h00;
  // crc residue over the whole frame, crc bytes included, is zero
  wire        crc_good = rx_crc_q == 16'h0000;
  wire        frame_end = state_q == ST_LISTEN && rx_cnt_q != 4'h0
                       && idle_q == SILENCE_CYCLES - 32'h0000_0001;
  wire        frame_ok = rx_cnt_q == `MSRS_QUERY_BYTES && !rx_bad_q
                      && crc_good && addr_hit;
  wire        req_ok   = (is_read && rd_ok) || (is_write && wr_ok);
  wire        do_write = frame_end && frame_ok && is_write && wr_ok;
  wire [15:0] wr_index = q_q.offset - `MSRS_WRITE_FIRST;

  // ********************************************
  // sensor register view
  // ********************************************
  wire        units_f  = hold_q[4'(`MSRS_OFF_UNITS - `MSRS_WRITE_FIRST)][0];
  // temperature and humidity above full scale are pinned to the top rather than wrapped
  wire [15:0] temp_c   = temp_tenths_c > `MSRS_TEMP_MAX_C ?
                         `MSRS_TEMP_MAX_C : temp_tenths_c;
  wire [15:0] hum_word = humidity_pct > `MSRS_HUM_MAX ?
                         `MSRS_HUM_MAX : humidity_pct;
  wire [15:0] sense_word [0:4];

  // input pulls to common when shorted, so a shorted contact reads one
  assign sense_word[0] = {15'h0000, fit_s.di & sns_s.di_shorted};
  assign sense_word[1] = units_f ? tenths_c_to_f(temp_c) : temp_c;
  assign sense_word[2] = fit_s.rh ? hum_word : 16'h0000;
  assign sense_word[3] = (fit_s.fan && sns_s.fan_pos <= `MSRS_FAN_MAX) ?
                         {13'h0000, sns_s.fan_pos} : 16'h0000;
  assign sense_word[4] = {15'h0000, hold_flag_q};

  // ********************************************
  // reply byte selection
  // ********************************************
  // data bytes start at reply byte 3; two bytes per register
  wire [5:0]  data_idx = idx_q - 6'h03;
  wire [4:0]  rd_off   = 5'(q_q.offset) + 5'(data_idx[5:1]);
  wire [15:0] rd_word  = rd_off < 5'h05 ? sense_word[rd_off[2:0]]
                                        : hold_q[4'(rd_off - 5'h05)];
  wire [7:0]  rd_byte  = data_idx[0] ? rd_word[7:0] : rd_word[15:8];
  wire [7:0]  rd_count = {q_q.word[6:0], 1'b0};
  wire [5:0]  body_len = kind_q == REPLY_READ  ? 6'(rd_count) + 6'h03 :
                         kind_q == REPLY_WRITE ? 6'h06 : 6'h03;
  wire        last_done = idx_q == body_len + 6'h02;
  logic [7:0] body_byte;

  always_comb begin
    body_byte = q_q.addr;
    unique case (kind_q)
      REPLY_READ: begin
        if (idx_q == 6'h01) begin
          body_byte = `MSRS_FC_READ;
        end else if (idx_q == 6'h02) begin
          body_byte = rd_count;
        end else if (idx_q >= 6'h03) begin
          body_byte = rd_byte;
        end
      end
      REPLY_WRITE: begin
        unique case (idx_q)
          6'h01:   body_byte = `MSRS_FC_WRITE;
          6'h02:   body_byte = q_q.offset[15:8];
          6'h03:   body_byte = q_q.offset[7:0];
          6'h04:   body_byte = q_q.word[15:8];
          6'h05:   body_byte = q_q.word[7:0];
          default: body_byte = q_q.addr;
        endcase
      end
      REPLY_EXC: begin
        if (idx_q == 6'h01) begin
          body_byte = q_q.func | `MSRS_EXC_FLAG;
        end else if (idx_q == 6'h02) begin
          body_byte = exc_q;
        end
      end
      default: body_byte = q_q.addr;
    endcase
  end

  wire [7:0] out_byte = idx_q < body_len  ? body_byte :
                        idx_q == body_len ? tx_crc_q[7:0] :
                                            tx_crc_q[15:8];
  // latency counts from frame end; select zero leaves only the silence gap
  wire [31:0] lat_cycles = 32'(lat_s) * LAT_STEP_CYCLES;

  // ********************************************
  // receive side
  // ********************************************
  // bytes arriving while a reply is pending are dropped: the line is half duplex
  always_ff @(posedge clock) begin
    if (reset || state_q != ST_LISTEN || frame_end) begin
      rx_cnt_q <= 4'h0;
      rx_bad_q <= 1'b0;
      rx_crc_q <= `MSRS_CRC_INIT;
    end else if (rx_valid) begin
      rx_cnt_q <= rx_cnt_q == 4'hF ? rx_cnt_q : rx_cnt_q + 4'h1;
      rx_bad_q <= rx_bad_q | rx_error;
      rx_crc_q <= crc_step(rx_crc_q, rx_data);
    end
  end

  // only six bytes are kept; the crc bytes feed the residue alone
  always_ff @(posedge clock) begin
    if (reset) begin
      q_q <= '0;
    end else if (state_q == ST_LISTEN && rx_valid && rx_cnt_q < 4'h6) begin
      q_q <= {q_q[39:0], rx_data};
    end
  end

  // silence counter saturates so a quiet line never wraps into a false end
  always_ff @(posedge clock) begin
    if (reset || rx_valid || state_q != ST_LISTEN) begin
      idle_q <= 32'h0000_0000;
    end else if (idle_q != SILENCE_CYCLES) begin
      idle_q <= idle_q + 32'h0000_0001;
    end
  end

  // ********************************************
  // sequencing
  // ********************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_LISTEN;
      kind_q  <= REPLY_READ;
      exc_q   <= `MSRS_EXC_FUNC;
      wait_q  <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_LISTEN: begin
          wait_q <= 32'h0000_0000;
          // bad crc or foreign address: drop silently, no exception
          if (frame_end && frame_ok) begin
            state_q <= ST_WAIT;
            kind_q  <= req_ok ? (is_read ? REPLY_READ : REPLY_WRITE) : REPLY_EXC;
            exc_q   <= (is_read || is_write) ? `MSRS_EXC_ADDR : `MSRS_EXC_FUNC;
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 32'h0000_0001;
          if (wait_q >= lat_cycles) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!tx_valid_q && last_done) begin
            state_q <= ST_LISTEN;
          end
        end
        default: state_q <= ST_LISTEN;
      endcase
    end
  end

  // ********************************************
  // transmit side
  // ********************************************
  // one idle cycle between bytes keeps the handshake simple; the serial
  // engine is far slower so nothing is lost
  always_ff @(posedge clock) begin
    if (reset || state_q != ST_SEND) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      idx_q      <= 6'h00;
      tx_crc_q   <= `MSRS_CRC_INIT;
    end else if (!tx_valid_q) begin
      tx_valid_q <= !last_done;
      tx_data_q  <= out_byte;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
      idx_q      <= idx_q + 6'h01;
      if (idx_q < body_len) begin
        tx_crc_q <= crc_step(tx_crc_q, tx_data_q);
      end
    end
  end

  // driver stays on through byte gaps so the line never floats mid-reply
  always_ff @(posedge clock) begin
    if (reset) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= state_q == ST_SEND && !(last_done && !tx_valid_q);
    end
  end

  // ********************************************
  // holding registers and hold flag
  // ********************************************
  // holding words keep raw values; only the hold-clear offset is decoded in this block, the units offset in the sensor register view
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < `MSRS_HOLD_WORDS; i++) begin
        hold_q[i] <= `MSRS_HOLD_RESET;
      end
    end else if (do_write) begin
      hold_q[4'(wr_index)] <= q_q.word;
    end
  end

  // a press in the same cycle as a clearing write wins
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_flag_q <= 1'b0;
    end else if (fit_s.hold && sns_s.hold_press) begin
      hold_flag_q <= 1'b1;
    end else if (do_write && q_q.offset == `MSRS_OFF_HOLD_CLR
                 && q_q.word == 16'h0000) begin
      hold_flag_q <= 1'b0;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  // every output is a flip-flop, so the bit engine sees no decode glitches
  assign tx_valid   = tx_valid_q;
  assign tx_data    = tx_data_q;
  assign line_drive = drive_q;

endmodule

//--- bench/msrs_chk.sv
// concurrent checks on the reply stream of the query handler
`timescale 1ns/10ps
module msrs_chk #(
  parameter int unsigned SILENCE_CYCLES  = 40,
  parameter int unsigned LAT_STEP_CYCLES = 10
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       rx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] slave_address,
  input wire logic [2:0] latency_sel,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       line_drive
);
  logic [5:0]  idx_q;
  logic [7:0]  fn_q;
  logic [7:0]  bc_q;
  logic [31:0] quiet_q;
  logic [31:0] lat_w;
  logic        acc;
  assign acc = tx_valid && tx_ready;
  assign lat_w = SILENCE_CYCLES + 32'(latency_sel) * LAT_STEP_CYCLES;
  // byte position within a reply, cleared whenever the driver is off
  always_ff @(posedge clock) begin
    idx_q <= (reset || !line_drive) ? 6'h00 : idx_q + 6'(acc);
    fn_q <= (acc && idx_q == 6'h01) ? tx_data : fn_q;
    bc_q <= (acc && idx_q == 6'h02) ? tx_data : bc_q;
    quiet_q <= (reset || rx_valid) ? 32'h0 : quiet_q + 32'(quiet_q != 32'hFFFFFFFF);
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_valid_in_drive; tx_valid |-> line_drive; endproperty
  a_valid_in_drive: assert property (p_valid_in_drive) else $error("byte offered undriven");
  property p_gap; acc |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after accept");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("reply byte changed while stalled");
  property p_first_addr; $rose(line_drive) |-> tx_valid && tx_data == slave_address; endproperty
  a_first_addr: assert property (p_first_addr) else $error("reply not led by address");
  property p_func; tx_valid && idx_q == 6'h01 |-> tx_data inside {8'h03, 8'h06} || tx_data[7];
  endproperty
  a_func: assert property (p_func) else $error("bad reply function byte");
  property p_exc_code; tx_valid && idx_q == 6'h02 && fn_q[7] |-> tx_data inside {8'h01, 8'h02};
  endproperty
  a_exc_code: assert property (p_exc_code) else $error("bad exception code");
  property p_byte_count;
    tx_valid && idx_q == 6'h02 && fn_q == 8'h03 |-> !tx_data[0] && tx_data inside {[8'h02:8'h24]};
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("bad byte count");
  property p_length;
    $fell(line_drive) |-> idx_q == (fn_q[7] ? 6'h05 : fn_q == 8'h03 ? 6'h05 + bc_q[5:0] : 6'h08);
  endproperty
  a_length: assert property (p_length) else $error("reply length wrong");
  property p_silence; $rose(line_drive) |-> quiet_q >= lat_w && quiet_q <= lat_w + 32'h5;
  endproperty
  a_silence: assert property (p_silence) else $error("reply started at wrong time");
  c_read: cover property ($fell(line_drive) && fn_q == 8'h03);
  c_write: cover property ($fell(line_drive) && fn_q == 8'h06);
  c_exc: cover property ($fell(line_drive) && fn_q[7]);
endmodule

bind msrs_slave msrs_chk #(.SILENCE_CYCLES(SILENCE_CYCLES), .LAT_STEP_CYCLES(LAT_STEP_CYCLES))
  u_chk (.clock(clock), .reset(reset), .rx_valid(rx_valid), .tx_ready(tx_ready),
  .slave_address(slave_address), .latency_sel(latency_sel), .tx_valid(tx_valid),
  .tx_data(tx_data), .line_drive(line_drive));

//--- bench/msrs_master.sv
// behavioural bus master feeding query bytes and taking reply bytes
`timescale 1ns/10ps
`include "msrs_regs.svh"
module msrs_master (
  input  wire logic       clock,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_error,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  logic       slow;
  logic [7:0] reply[$];
  initial begin
    slow = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_error = 1'b0;
    tx_ready = 1'b1;
  end
  // ********************************
  // reply side, stalls every other cycle when slow
  // ********************************
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clock) if (tx_valid && tx_ready) reply.push_back(tx_data);
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `MSRS_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `MSRS_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // bad flips the low crc bit, err flags the fourth byte
  task automatic send_query(input logic [7:0] a, f, input logic [15:0] o, w, input logic bad, err);
    logic [7:0]  q[$];
    logic [15:0] c;
    q = {a, f, o[15:8], o[7:0], w[15:8], w[7:0]};
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    reply.delete();
    foreach (q[i]) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_error = err && i == 3;
      @(negedge clock);
      rx_valid = 1'b0;
      rx_data = ~q[i];
      rx_error = 1'b0;
      repeat (2) @(negedge clock);
    end
  endtask
endmodule

//--- bench/msrs_slave_tb.sv
// self-checking bench for the query handler
`timescale 1ns/10ps
`include "msrs_regs.svh"
module msrs_slave_tb;
  import msrs_pkg::*;
  localparam int SIL = 40;
  localparam int LAT = 10;
  typedef struct packed {
    logic [7:0]  fn;
    logic [15:0] off;
    logic [15:0] word;
    logic [7:0]  exc;
  } msrs_row_t;
  logic        clock = 1'b0, reset = 1'b1, rx_valid, rx_error, tx_ready, tx_valid, line_drive;
  logic [7:0]  rx_data, tx_data, slave_address = 8'h01;
  logic [2:0]  latency_sel = 3'h0;
  msrs_sense_t sense = 5'h16;
  msrs_fit_t   fitted = 4'hF;
  logic [15:0] temp_tenths_c = 16'h01F4, humidity_pct = 16'h0064;
  logic [15:0] hreg [18];
  logic        hold_m = 1'b0;
  int          fail_count = 0, cmp_count = 0, n;
  msrs_row_t rows [18] = '{
    '{8'h03, 16'h0000, 16'h0005, 8'h00}, '{8'h06, 16'h0005, 16'hFFFF, 8'h00},
    '{8'h06, 16'h0011, 16'h0000, 8'h00}, '{8'h06, 16'h000A, 16'h1234, 8'h00},
    '{8'h03, 16'h0009, 16'h0002, 8'h00}, '{8'h03, 16'h000A, 16'h0008, 8'h00},
    '{8'h03, 16'h000A, 16'h0009, 8'h02}, '{8'h03, 16'h0012, 16'h0001, 8'h02},
    '{8'h03, 16'h0000, 16'h0000, 8'h02}, '{8'h03, 16'h0000, 16'h0012, 8'h00},
    '{8'h06, 16'h0004, 16'h0001, 8'h02}, '{8'h06, 16'h0012, 16'h0001, 8'h02},
    '{8'h04, 16'h0000, 16'h0001, 8'h01}, '{8'h06, 16'h000B, 16'h0001, 8'h00},
    '{8'h03, 16'h0001, 16'h0001, 8'h00}, '{8'h06, 16'h000B, 16'h0000, 8'h00},
    '{8'h03, 16'h0001, 16'h0001, 8'h00}, '{8'h03, 16'h0011, 16'h0001, 8'h00}};
  always #4 clock = ~clock;
  always @(posedge clock) if (sense.hold_press && fitted.hold) hold_m <= 1'b1;
  msrs_slave #(.SILENCE_CYCLES(SIL), .LAT_STEP_CYCLES(LAT)) dut (.clock(clock), .reset(reset),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error), .tx_ready(tx_ready),
    .slave_address(slave_address), .latency_sel(latency_sel), .sense(sense), .fitted(fitted),
    .temp_tenths_c(temp_tenths_c), .humidity_pct(humidity_pct), .tx_valid(tx_valid),
    .tx_data(tx_data), .line_drive(line_drive));
  msrs_master master (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_error(rx_error), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  // ********************************
  // helpers
  // ********************************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] reg_val(input logic [15:0] k);
    logic [15:0] t, h;
    t = temp_tenths_c > `MSRS_TEMP_MAX_C ? `MSRS_TEMP_MAX_C : temp_tenths_c;
    h = humidity_pct > `MSRS_HUM_MAX ? `MSRS_HUM_MAX : humidity_pct;
    case (k)
      16'h0000: return {15'h0000, fitted.di & sense.di_shorted};
      16'h0001: return hreg[11][0] ? t * 16'h9 / 16'h5 + `MSRS_F_ZERO : t;
      16'h0002: return fitted.rh ? h : 16'h0000;
      16'h0003: return (fitted.fan && sense.fan_pos <= 3'h4) ? {13'h0000, sense.fan_pos} : 16'h0;
      16'h0004: return {15'h0000, hold_m};
      default: return hreg[k];
    endcase
  endfunction
  task automatic wait_drive(input logic want);
    for (n = 0; line_drive !== 1'b1 && n < SIL + 8 * LAT + 40; n++) @(negedge clock);
    check(16'(line_drive === 1'b1), 16'(want));
    if (want) check(16'(n + 8 >= SIL + latency_sel * LAT), 16'h0001);
    if (want && line_drive !== 1'b1) give_verdict;
    for (n = 0; line_drive !== 1'b0 && n < 800; n++) @(negedge clock);
    if (n >= 800) begin
      fail_count++;
      give_verdict;
    end
  endtask
  task automatic query(input msrs_row_t r);
    logic [7:0]  e[$];
    logic [15:0] c;
    master.send_query(slave_address, r.fn, r.off, r.word, 1'b0, 1'b0);
    wait_drive(1'b1);
    e = {slave_address, r.fn | (r.exc != 8'h00 ? `MSRS_EXC_FLAG : 8'h00)};
    if (r.exc != 8'h00) e.push_back(r.exc);
    else if (r.fn == `MSRS_FC_READ) begin
      e.push_back(r.word[6:0] * 8'h02);
      for (int k = 0; k < r.word; k++) begin
        c = reg_val(16'(r.off + k));
        e = {e, c[15:8], c[7:0]};
      end
    end else begin
      e = {e, r.off[15:8], r.off[7:0], r.word[15:8], r.word[7:0]};
      hreg[r.off] = r.word;
      if (r.off == `MSRS_OFF_HOLD_CLR && r.word == 16'h0000) hold_m = 1'b0;
    end
    c = master.crc16(e);
    e = {e, c[7:0], c[15:8]};
    check(16'(master.reply.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, master.reply[i]}, {8'h00, e[i]});
    $display("case %h %h %h done", r.fn, r.off, r.word);
  endtask
  task automatic do_reset(input int cyc);
    @(negedge clock);
    reset = 1'b1;
    repeat (cyc) @(negedge clock);
    reset = 1'b0;
    foreach (hreg[k]) hreg[k] = `MSRS_HOLD_RESET;
    hold_m = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    do_reset(3);
    check({14'h0000, tx_valid, line_drive}, 16'h0000);
    foreach (rows[i]) begin
      master.slow = i[0];
      query(rows[i]);
    end
    // wrong address, bad crc on an unknown function, byte error: all silent
    for (int k = 0; k < 3; k++) begin
      master.send_query(8'h01 + 8'(k == 0), k == 1 ? 8'h04 : 8'h03, 16'h0, 16'h1, k == 1, k == 2);
      wait_drive(1'b0);
      $display("refusal %0d done", k);
    end
    for (int f = 0; f < 6; f++) begin
      @(negedge clock);
      sense.fan_pos = 3'(f);
      query('{8'h03, 16'h0003, 16'h0001, 8'h00});
    end
    @(negedge clock);
    fitted = 4'h0;
    sense.hold_press = 1'b1;
    query('{8'h03, 16'h0000, 16'h0004, 8'h00});
    fitted = 4'hF;
    sense.di_shorted = 1'b0;
    repeat (4) @(negedge clock);
    sense.hold_press = 1'b0;
    query('{8'h03, 16'h0000, 16'h0005, 8'h00});
    query('{8'h06, 16'h000E, 16'h0000, 8'h00});
    query('{8'h03, 16'h0004, 16'h0001, 8'h00});
    // readings above full scale must read back pinned to the top of range
    temp_tenths_c = 16'h0258;
    humidity_pct = 16'h00C8;
    query('{8'h03, 16'h0001, 16'h0002, 8'h00});
    temp_tenths_c = 16'h00EB;
    humidity_pct = 16'h0032;
    query('{8'h03, 16'h0001, 16'h0002, 8'h00});
    slave_address = 8'hFF;
    latency_sel = 3'h7;
    master.slow = 1'b1;
    repeat (3) @(negedge clock);
    query('{8'h03, 16'h0002, 16'h0001, 8'h00});
    master.send_query(slave_address, 8'h03, 16'h0000, 16'h0012, 1'b0, 1'b0);
    for (n = 0; line_drive !== 1'b1 && n < 200; n++) @(negedge clock);
    check(16'(line_drive === 1'b1), 16'h0001);
    if (line_drive !== 1'b1) give_verdict;
    do_reset(2);
    check({14'h0000, tx_valid, line_drive}, 16'h0000);
    query('{8'h03, 16'h0005, 16'h000D, 8'h00});
    give_verdict;
  end
endmodule
